// ===== fault_manager.sv
// gate driver fault manager: detection, reactions, flags and apb registers
`timescale 1ns/1ps
module fault_manager #(
    parameter int RETRY_CYCLES = fault_pkg::RETRY_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic enable_pin,
    input wire logic pump_low_cmp,
    input wire logic thermal_cmp,
    input wire logic [5:0] drain_cmp,
    input wire logic [2:0] shunt_cmp,
    input wire logic [5:0] vgs_high,
    input wire logic [5:0] vgs_low,
    input wire logic [5:0] gate_inputs,
    output logic fault_out_n_o,
    output logic fault_out_n_oe_n,
    output logic driver_hiz,
    output logic driver_pulldown,
    output logic [3:0] drain_threshold_sel,
    output logic [1:0] shunt_threshold_sel,
    output logic [1:0] gate_transition_sel,
    output logic [3:0] high_side_drive_strength,
    output logic [3:0] low_side_drive_strength
);
    localparam logic [19:0] RETRY_LAST = 20'(RETRY_CYCLES - 1);

    fault_pkg::state_t st;
    fault_pkg::state_t n;
    fault_pkg::pins_t pins_async;
    fault_pkg::pins_t pins;
    fault_pkg::status_t status;
    fault_pkg::oc_mode_t drain_mode;
    fault_pkg::oc_mode_t shunt_mode;
    logic [8:0] filt_raw;
    logic [8:0] filt_det;
    logic [5:0] drain_det;
    logic [2:0] shunt_det;
    logic [5:0] gate_fail;
    logic [9:0] deglitch_limit;
    logic drivers_off;
    logic access;
    logic done;
    logic wr_clear;
    logic en_rise;
    logic clr_ev;
    logic expire;
    logic drain_rep;
    logic drain_act;
    logic drain_clr;
    logic shunt_rep;
    logic shunt_act;
    logic shunt_clr;
    logic retry_start;
    logic fault_low;

    // every pin from outside the clock domain goes through two flops
    assign pins_async = '{enable_pin, pump_low_cmp, thermal_cmp, drain_cmp, shunt_cmp,
                          vgs_high, vgs_low, gate_inputs};

    pin_sync #(.W($bits(fault_pkg::pins_t))) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(pins_async),
        .sync_out(pins)
    );

    // only a switched-on, driven fet can show a valid drain drop
    assign drivers_off = st.drv_hiz | st.drv_pulldown;
    assign filt_raw = {pins.shunt_cmp, pins.drain_cmp & pins.gate_inputs & ~{6{drivers_off}}};
    assign deglitch_limit = fault_pkg::DEGLITCH_CYC[st.ctrl.deglitch_sel];

    generate
        for (genvar g = 0; g < 9; g++) begin : g_filt
            deglitch_filter u_filt (
                .pclk(pclk),
                .presetn(presetn),
                .raw(filt_raw[g]),
                .limit(deglitch_limit),
                .detect(filt_det[g])
            );
        end
    endgenerate

    assign drain_det = filt_det[5:0];
    assign shunt_det = filt_det[8:6] & ~st.ctrl.per_channel_shunt_off;
    assign drain_mode = fault_pkg::oc_mode_t'(st.ctrl.drain_oc_reaction);
    assign shunt_mode = fault_pkg::oc_mode_t'(st.ctrl.shunt_oc_reaction);

    // apb: one wait state, so pready and read data come from flops
    assign access = psel & penable;
    assign done = access & st.pready;
    assign wr_clear = done & pwrite & (paddr == fault_pkg::CTRL_OFFSET) & pwdata[0];
    assign en_rise = pins.enable_pin & ~st.en_prev;
    assign clr_ev = wr_clear | en_rise;
    assign expire = st.retry_run & (st.retry_cnt == RETRY_LAST);

    // status word assembled from the live flags
    always_comb begin
        status = '0;
        status.per_fet_gate_flag = st.gate_fets;
        status.per_channel_shunt_flag = st.shunt_chs;
        status.per_fet_drain_oc_flag = st.drain_fets;
        status.thermal_warning_flag = st.hot_flag;
        status.gate_voltage_flag = st.gate_flag;
        status.shunt_overcurrent_flag = st.shunt_flag;
        status.drain_overcurrent_flag = st.drain_flag;
        status.pump_low_flag = st.pump_flag;
        status.fault_summary = st.pump_flag | st.drain_flag | st.shunt_flag | st.gate_flag;
    end

    // gate check fires when the limit count runs out after an input edge
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            gate_fail[i] = (st.gate_cnt[i] == 10'h001) &
                           (pins.gate_inputs[i] ? ~pins.vgs_high[i] : ~pins.vgs_low[i]);
        end
    end

    // reaction decisions for both overcurrent detectors
    always_comb begin
        drain_rep = (drain_mode != fault_pkg::OC_OFF) & (|drain_det);
        drain_act = drain_rep & ((drain_mode == fault_pkg::OC_LATCH) | (drain_mode == fault_pkg::OC_RETRY));
        drain_clr = (clr_ev & ((drain_mode != fault_pkg::OC_REPORT) | ~(|drain_det))) |
                    (expire & st.drain_retry);
        shunt_rep = (shunt_mode != fault_pkg::OC_OFF) & (|shunt_det);
        shunt_act = shunt_rep & ((shunt_mode == fault_pkg::OC_LATCH) | (shunt_mode == fault_pkg::OC_RETRY));
        shunt_clr = (clr_ev & ((shunt_mode != fault_pkg::OC_REPORT) | ~(|shunt_det))) |
                    (expire & st.shunt_retry);
        retry_start = (drain_act & (drain_mode == fault_pkg::OC_RETRY)) |
                      (shunt_act & (shunt_mode == fault_pkg::OC_RETRY));
    end

    // next state of the whole block
    always_comb begin
        n = st;
        n.en_prev = pins.enable_pin;
        n.hot_flag = pins.thermal_cmp;
        // charge pump: flags latched, drivers blocked only with detection on
        n.pump_flag = (st.pump_flag & ~clr_ev) | pins.pump_low_cmp;
        n.pump_block = (st.pump_block & ~clr_ev) | (pins.pump_low_cmp & ~st.ctrl.pump_low_detect_off);
        // drain overcurrent, set beats clear
        n.drain_fets = (drain_clr ? 6'h00 : st.drain_fets) | (drain_rep ? drain_det : 6'h00);
        n.drain_flag = (st.drain_flag & ~drain_clr) | drain_rep;
        n.drain_block = (st.drain_block & ~(clr_ev | (expire & st.drain_retry))) | drain_act;
        n.drain_retry = (st.drain_retry & ~(clr_ev | expire)) |
                        (drain_act & (drain_mode == fault_pkg::OC_RETRY));
        // shunt overcurrent
        n.shunt_chs = (shunt_clr ? 3'h0 : st.shunt_chs) | (shunt_rep ? shunt_det : 3'h0);
        n.shunt_flag = (st.shunt_flag & ~shunt_clr) | shunt_rep;
        n.shunt_block = (st.shunt_block & ~(clr_ev | (expire & st.shunt_retry))) | shunt_act;
        n.shunt_retry = (st.shunt_retry & ~(clr_ev | expire)) |
                        (shunt_act & (shunt_mode == fault_pkg::OC_RETRY));
        // gate-source fault, suppressed entirely by its disable bit
        n.gate_fets = (clr_ev ? 6'h00 : st.gate_fets) | (st.ctrl.gate_check_off ? 6'h00 : gate_fail);
        n.gate_flag = (st.gate_flag & ~clr_ev) | ((|gate_fail) & ~st.ctrl.gate_check_off);
        n.gate_block = (st.gate_block & ~clr_ev) | ((|gate_fail) & ~st.ctrl.gate_check_off);
        n.gate_prev = pins.gate_inputs;
        // gate transition timers restart on each input edge and idle while blocked
        for (int i = 0; i < 6; i++) begin
            if (drivers_off) begin
                n.gate_cnt[i] = 10'h000;
            end else if (pins.gate_inputs[i] != st.gate_prev[i]) begin
                n.gate_cnt[i] = fault_pkg::GATE_LIMIT_CYC[st.cfg.gate_transition_sel];
            end else if (st.gate_cnt[i] != 10'h000) begin
                n.gate_cnt[i] = st.gate_cnt[i] - 10'h001;
            end
        end
        // retry delay counter; a fresh retry fault restarts it
        if (retry_start) begin
            n.retry_run = 1'b1;
            n.retry_cnt = 20'h0_0000;
        end else if (expire | clr_ev) begin
            n.retry_run = 1'b0;
            n.retry_cnt = 20'h0_0000;
        end else if (st.retry_run) begin
            n.retry_cnt = st.retry_cnt + 20'h0_0001;
        end
        // pin low for live pump condition, live thermal condition with its report bit, and latched drain/shunt/gate flags
        fault_low = pins.pump_low_cmp | n.drain_flag | n.shunt_flag | n.gate_flag |
                    (pins.thermal_cmp & st.ctrl.thermal_warning_report);
        n.fault_oe_n = ~fault_low;
        // pump and gate faults always Hi-Z; overcurrent honours the pulldown choice
        n.drv_hiz = n.pump_block | n.gate_block |
                    ((n.drain_block | n.shunt_block) & ~st.ctrl.output_pulldown_sel);
        n.drv_pulldown = (n.drain_block | n.shunt_block) & st.ctrl.output_pulldown_sel &
                         ~(n.pump_block | n.gate_block);
        // apb slave
        n.pready = access & ~st.pready;
        if (access & ~st.pready) begin
            n.pslverr = 1'b0;
            unique case (paddr)
                fault_pkg::CTRL_OFFSET: n.prdata = st.ctrl;
                fault_pkg::CONFIG_OFFSET: n.prdata = st.cfg;
                fault_pkg::STATUS_OFFSET: n.prdata = status;
                default: begin
                    n.prdata = 32'h0000_0000;
                    n.pslverr = 1'b1;
                end
            endcase
        end
        if (done & pwrite) begin
            if (paddr == fault_pkg::CTRL_OFFSET) begin
                n.ctrl = fault_pkg::ctrl_t'(pwdata);
                n.ctrl.unused = '0;
            end
            if (paddr == fault_pkg::CONFIG_OFFSET) begin
                n.cfg = fault_pkg::config_t'(pwdata);
                n.cfg.unused = '0;
            end
        end
        n.ctrl.clear_faults_cmd = 1'b0; // self-clearing, reads zero
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.fault_oe_n <= 1'b1;
            st.ctrl <= fault_pkg::CTRL_RESET;
            st.cfg <= fault_pkg::CONFIG_RESET;
        end else begin
            st <= n;
        end
    end

    // outputs straight from flops; open-drain data is a constant low
    assign fault_out_n_o = 1'b0;
    assign fault_out_n_oe_n = st.fault_oe_n;
    assign driver_hiz = st.drv_hiz;
    assign driver_pulldown = st.drv_pulldown;
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign drain_threshold_sel = st.cfg.drain_threshold_sel;
    assign shunt_threshold_sel = st.cfg.shunt_threshold_sel;
    assign gate_transition_sel = st.cfg.gate_transition_sel;
    assign high_side_drive_strength = st.cfg.high_side_drive_strength;
    assign low_side_drive_strength = st.cfg.low_side_drive_strength;

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_retry_armed;
        retry_start ##1 st.retry_run;
    endsequence

    sequence s_retry_done;
        expire ##1 !st.retry_run;
    endsequence

    a_pump_pin_low: assert property (pins.pump_low_cmp |=> !fault_out_n_oe_n)
        else $error("pump low did not pull fault pin");
    a_pump_blocks: assert property (pins.pump_low_cmp && !st.ctrl.pump_low_detect_off |=> driver_hiz)
        else $error("pump low did not block drivers");
    a_pump_keeps: assert property (pins.pump_low_cmp && st.ctrl.pump_low_detect_off && !st.pump_block
                                   |=> !st.pump_block && st.pump_flag)
        else $error("pump low changed state with detection off");
    a_drain_off_mode: assert property (drain_mode == fault_pkg::OC_OFF && !st.drain_flag && !drain_clr
                                       |=> !st.drain_flag)
        else $error("drain fault reported in off mode");
    a_drain_latch: assert property ((|drain_det) && drain_mode == fault_pkg::OC_LATCH
                                    |=> st.drain_flag && st.drain_block && !fault_out_n_oe_n)
        else $error("drain latch reaction missing");
    a_retry_timer: assert property (s_retry_armed |-> st.retry_cnt == 20'h0_0000)
        else $error("retry counter not restarted");
    a_retry_release: assert property (s_retry_done |-> !st.drain_retry && !st.shunt_retry)
        else $error("retry expiry did not release");
    a_drain_report: assert property ((|drain_det) && drain_mode == fault_pkg::OC_REPORT && !drivers_off
                                     && !st.drain_block |=> !st.drain_block && st.drain_flag)
        else $error("report-only mode acted on drivers");
    a_shunt_masked: assert property (shunt_det == 3'h0 && !st.shunt_flag |=> !st.shunt_flag)
        else $error("masked shunt channel reported");
    a_thermal_follow: assert property (st.hot_flag == $past(pins.thermal_cmp))
        else $error("thermal flag not following comparator");
    a_thermal_pin: assert property (pins.thermal_cmp && st.ctrl.thermal_warning_report |=> !fault_out_n_oe_n)
        else $error("thermal report did not pull pin");
    a_set_wins: assert property (clr_ev && pins.pump_low_cmp |=> st.pump_flag)
        else $error("clear beat a simultaneous pump event");
    a_gate_fault: assert property ((|gate_fail) && !st.ctrl.gate_check_off |=> st.gate_flag ##0 driver_hiz)
        else $error("gate fault reaction missing");
    a_apb_answer: assert property (access && !pready |=> pready ##1 !pready)
        else $error("apb answer timing wrong");
endmodule // fault_manager

// ===== fault_pkg.sv
// constants, register layouts and state types of the gate driver fault manager
// What this block does
// - pump low: block drivers, pin low, latch flags
// - pump recovery frees pin; clear re-enables drivers
// - pump detect off: pin follows condition, flags latched
// - drain overcurrent needs enabled FET, deglitched comparator
// - drain mode 11b: no action, no report
// - drain latch: block or pull down, latch flags
// - retry mode: release and resume after retry delay
// - drain retry honours the pulldown selection
// - drain report only: drivers active, flags latched
// - shunt overcurrent per channel, deglitched, own mode
// - per-channel shunt disable suppresses action and report
// - shunt latch: block, pin low, latch flags
// - shunt report only: clears after condition gone
// - gate voltage checked after transition limit
// - gate fault cleared by clear; disable bit
// - thermal warning flag follows comparator, no action
// - thermal report bit drives pin low
// - enable low pulse or clear command clears
// - pin low while any enabled fault active
package fault_pkg;
    localparam int CLK_MHZ = 50;
    localparam int NS_PER_US = 1000;

    // register byte offsets
    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] CONFIG_OFFSET = 12'h004;
    localparam logic [11:0] STATUS_OFFSET = 12'h008;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;

    // deglitch times per selection, cycle counts round up
    localparam int DEGLITCH_NS [4] = '{1000, 2000, 4000, 8000};
    localparam logic [9:0] DEGLITCH_CYC [4] = '{
        10'((DEGLITCH_NS[0] * CLK_MHZ + NS_PER_US - 1) / NS_PER_US),
        10'((DEGLITCH_NS[1] * CLK_MHZ + NS_PER_US - 1) / NS_PER_US),
        10'((DEGLITCH_NS[2] * CLK_MHZ + NS_PER_US - 1) / NS_PER_US),
        10'((DEGLITCH_NS[3] * CLK_MHZ + NS_PER_US - 1) / NS_PER_US)};
    // gate transition limit per selection
    localparam int GATE_LIMIT_NS [4] = '{500, 1000, 2000, 4000};
    localparam logic [9:0] GATE_LIMIT_CYC [4] = '{
        10'((GATE_LIMIT_NS[0] * CLK_MHZ + NS_PER_US - 1) / NS_PER_US),
        10'((GATE_LIMIT_NS[1] * CLK_MHZ + NS_PER_US - 1) / NS_PER_US),
        10'((GATE_LIMIT_NS[2] * CLK_MHZ + NS_PER_US - 1) / NS_PER_US),
        10'((GATE_LIMIT_NS[3] * CLK_MHZ + NS_PER_US - 1) / NS_PER_US)};
    // retry delay
    localparam int RETRY_DELAY_US = 1000;
    localparam int RETRY_CYC = RETRY_DELAY_US * CLK_MHZ;

    typedef enum logic [1:0] {
        OC_LATCH = 2'b00,
        OC_RETRY = 2'b01,
        OC_REPORT = 2'b10,
        OC_OFF = 2'b11
    } oc_mode_t;

    typedef struct packed {
        logic [17:0] unused;
        logic [1:0] deglitch_sel;
        logic [2:0] per_channel_shunt_off;
        logic [1:0] shunt_oc_reaction;
        logic [1:0] drain_oc_reaction;
        logic gate_check_off;
        logic pump_low_detect_off;
        logic output_pulldown_sel;
        logic thermal_warning_report;
        logic clear_faults_cmd;
    } ctrl_t;

    typedef struct packed {
        logic [15:0] unused;
        logic [3:0] low_side_drive_strength;
        logic [3:0] high_side_drive_strength;
        logic [1:0] gate_transition_sel;
        logic [1:0] shunt_threshold_sel;
        logic [3:0] drain_threshold_sel;
    } config_t;

    typedef struct packed {
        logic [10:0] unused;
        logic [5:0] per_fet_gate_flag;
        logic [2:0] per_channel_shunt_flag;
        logic [5:0] per_fet_drain_oc_flag;
        logic thermal_warning_flag;
        logic gate_voltage_flag;
        logic shunt_overcurrent_flag;
        logic drain_overcurrent_flag;
        logic pump_low_flag;
        logic fault_summary;
    } status_t;

    // asynchronous inputs, synchronised as one vector
    typedef struct packed {
        logic enable_pin;
        logic pump_low_cmp;
        logic thermal_cmp;
        logic [5:0] drain_cmp;
        logic [2:0] shunt_cmp;
        logic [5:0] vgs_high;
        logic [5:0] vgs_low;
        logic [5:0] gate_inputs;
    } pins_t;

    typedef struct packed {
        logic en_prev;
        logic pump_flag;
        logic pump_block;
        logic drain_flag;
        logic [5:0] drain_fets;
        logic drain_block;
        logic drain_retry;
        logic shunt_flag;
        logic [2:0] shunt_chs;
        logic shunt_block;
        logic shunt_retry;
        logic gate_flag;
        logic [5:0] gate_fets;
        logic gate_block;
        logic [5:0] gate_prev;
        logic [5:0][9:0] gate_cnt;
        logic hot_flag;
        logic retry_run;
        logic [19:0] retry_cnt;
        logic fault_oe_n;
        logic drv_hiz;
        logic drv_pulldown;
        ctrl_t ctrl;
        config_t cfg;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } state_t;
endpackage

// ===== pin_sync.sv
// two-stage synchroniser for asynchronous input pins
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_state_t;

    sync_state_t st_reg;
    sync_state_t st_next;

    // first stage feeds only the second stage
    always_comb begin
        st_next.meta = async_in;
        st_next.stable = st_reg.meta;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sync_out = st_reg.stable;
endmodule // pin_sync

// ===== deglitch_filter.sv
// comparator deglitch counter: output only after the input held long enough
`timescale 1ns/1ps
module deglitch_filter (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic raw,
    input wire logic [9:0] limit,
    output logic detect
);
    typedef struct packed {
        logic [9:0] cnt;
        logic det;
    } deglitch_state_t;

    deglitch_state_t st_reg;
    deglitch_state_t st_next;

    // any drop restarts the count, so short spikes never reach the output
    always_comb begin
        st_next = st_reg;
        if (!raw) begin
            st_next.cnt = 10'h000;
            st_next.det = 1'b0;
        end else if (st_reg.cnt >= limit) begin
            st_next.det = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 10'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign detect = st_reg.det;
endmodule // deglitch_filter

// ===== host_model.sv
// host controller model: apb master, enable pin and gate inputs
`timescale 1ns/1ps
module host_model (
    input wire logic pclk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic enable_pin,
    output logic [5:0] gate_inputs
);
    // idle bus, device enabled, phase a high side on
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        enable_pin = 1'b1;
        gate_inputs = 6'h01;
    end

    // one transfer; request held until pready is sampled, then released
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // enable low pulse: the rising edge clears latched faults
    task en_pulse;
        @(posedge pclk) enable_pin <= 1'b0;
        repeat (4) @(posedge pclk);
        enable_pin <= 1'b1;
    endtask

    // host takes over switching itself
    task gate(input logic [5:0] v);
        @(posedge pclk) gate_inputs <= v;
    endtask
endmodule // host_model

// ===== fault_manager_test.sv
// self-checking bench for the gate driver fault manager
`timescale 1ns/1ps
module fault_manager_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, en, oe_n, hiz, pd, e, od;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [5:0] gi;
    wire [15:0] cfg;
    fault_pkg::pins_t p;
    int miscompares = 0;
    int compares = 0;
    int cyc = 0;

    always #10 pclk = ~pclk;

    fault_manager #(.RETRY_CYCLES(20)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .enable_pin(en), .pump_low_cmp(p.pump_low_cmp), .thermal_cmp(p.thermal_cmp), .drain_cmp(p.drain_cmp),
        .shunt_cmp(p.shunt_cmp), .vgs_high(p.vgs_high), .vgs_low(p.vgs_low), .gate_inputs(gi),
        .fault_out_n_o(od), .fault_out_n_oe_n(oe_n), .driver_hiz(hiz), .driver_pulldown(pd),
        .drain_threshold_sel(cfg[3:0]), .shunt_threshold_sel(cfg[5:4]), .gate_transition_sel(cfg[7:6]),
        .high_side_drive_strength(cfg[11:8]), .low_side_drive_strength(cfg[15:12]));

    host_model host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .enable_pin(en), .gate_inputs(gi));

    task end_sim;
        if (miscompares == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // a hang costs one mismatch and ends the run
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares++;
            end_sim;
        end
    end

    task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask

    task cw(input logic [31:0] v);
        host.xfer(1'b1, fault_pkg::CTRL_OFFSET, v, d, e);
    endtask

    // pins sampled mid-cycle so registered outputs have settled
    task look(input int n, input logic [2:0] eo, input logic [31:0] es);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
        chk("pin_hiz_pd", {28'h0, od, oe_n, hiz, pd}, {29'h0, eo});
        host.xfer(1'b0, fault_pkg::STATUS_OFFSET, 32'h0, d, e);
        chk("status", d, es);
    endtask

    task regs;
        look(0, 3'h4, 32'h0);
        host.xfer(1'b0, fault_pkg::CTRL_OFFSET, 32'h0, d, e);
        chk("ctrl", d, fault_pkg::CTRL_RESET);
        host.xfer(1'b1, fault_pkg::CONFIG_OFFSET, 32'h0000_ffff, d, e);
        host.xfer(1'b0, fault_pkg::CONFIG_OFFSET, 32'h0, d, e);
        chk("config", d, 32'h0000_ffff);
        chk("config_pins", {16'h0, cfg}, 32'h0000_ffff);
        host.xfer(1'b0, 12'h00c, 32'h0, d, e);
        chk("unmapped_err", {31'h0, e}, 32'h0000_0001);
        chk("unmapped_data", d, 32'h0);
    endtask

    // unqualified fet, then a pulse shorter than the deglitch count
    task qualify;
        cw(32'h0000_1000); // second deglitch choice: a first-choice count would trip
        @(posedge pclk) p.drain_cmp <= 6'h02;
        look(64, 3'h4, 32'h0);
        @(posedge pclk) p.drain_cmp <= 6'h01;
        repeat (90) @(posedge pclk);
        p.drain_cmp <= 6'h00;
        look(30, 3'h4, 32'h0);
    endtask

    task drain_modes;
        logic [2:0] blk;
        for (int m = 0; m < 4; m++) begin
            cw((32'(m) << 5) | (m == 0 ? 32'h0000_0004 : 32'h0));
            @(posedge pclk) p.drain_cmp <= 6'h01;
            blk = m == 3 ? 3'h4 : m == 0 ? 3'h1 : m == 1 ? 3'h2 : 3'h0;
            look(64, blk, m == 3 ? 32'h0 : 32'h0000_0045);
            @(posedge pclk) p.drain_cmp <= 6'h00;
            look(30, m[0] ? 3'h4 : blk, m[0] ? 32'h0 : 32'h0000_0045);
            host.en_pulse();
            look(6, 3'h4, 32'h0);
        end
    endtask

    task pump;
        cw(32'h0);
        @(posedge pclk) p.pump_low_cmp <= 1'b1;
        look(6, 3'h2, 32'h0000_0003);
        @(posedge pclk) p.pump_low_cmp <= 1'b0;
        look(6, 3'h6, 32'h0000_0003);
        cw(32'h0000_0001);
        look(2, 3'h4, 32'h0);
        cw(32'h0000_0008);
        @(posedge pclk) p.pump_low_cmp <= 1'b1;
        look(6, 3'h0, 32'h0000_0003);
        @(posedge pclk) p.pump_low_cmp <= 1'b0;
        look(6, 3'h4, 32'h0000_0003);
        cw(32'h0000_0009);
        look(2, 3'h4, 32'h0);
    endtask

    // channel 0 unused and switched off by the host
    task shunt;
        cw(32'h0000_0300);
        @(posedge pclk) p.shunt_cmp <= 3'h1;
        look(64, 3'h4, 32'h0);
        @(posedge pclk) p.shunt_cmp <= 3'h2;
        look(64, 3'h0, 32'h0000_2009);
        cw(32'h0000_0301);
        look(2, 3'h0, 32'h0000_2009);
        @(posedge pclk) p.shunt_cmp <= 3'h0;
        cw(32'h0000_0301);
        look(2, 3'h4, 32'h0);
        cw(32'h0000_0200);
        @(posedge pclk) p.shunt_cmp <= 3'h2;
        look(64, 3'h2, 32'h0000_2009);
        @(posedge pclk) p.shunt_cmp <= 3'h0;
        host.en_pulse();
        look(6, 3'h4, 32'h0);
        // shunt off mode, then retry with the pulldown choice
        cw(32'h0000_0180);
        @(posedge pclk) p.shunt_cmp <= 3'h2;
        look(64, 3'h4, 32'h0);
        cw(32'h0000_0084);
        look(64, 3'h1, 32'h0000_2009);
        @(posedge pclk) p.shunt_cmp <= 3'h0;
        look(30, 3'h4, 32'h0);
    endtask

    task thermal_gate;
        @(posedge pclk) p.thermal_cmp <= 1'b1;
        look(4, 3'h4, 32'h0000_0020);
        cw(32'h0000_0002);
        look(2, 3'h0, 32'h0000_0020);
        @(posedge pclk) p.thermal_cmp <= 1'b0;
        look(4, 3'h4, 32'h0);
        host.gate(6'h00);
        look(180, 3'h4, 32'h0);
        look(30, 3'h2, 32'h0000_8011);
        cw(32'h0000_0001);
        look(2, 3'h4, 32'h0);
        @(posedge pclk) p.vgs_high <= 6'h00;
        cw(32'h0000_0010);
        host.gate(6'h01);
        look(210, 3'h4, 32'h0);
    endtask

    initial begin
        p = '0;
        p.vgs_high = 6'h01;
        p.vgs_low = 6'h3e;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        regs;
        qualify;
        drain_modes;
        pump;
        shunt;
        thermal_gate;
        end_sim;
    end
endmodule // fault_manager_test
